// [rtl/scd_pkg.sv]
// Purpose: shared constants and types for the system clock select/divider block
// Assumes: registers written through a simple byte write port from the cpu core
// Notes: offsets are the printed byte addresses of the register map
package scd_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [15:0] OSC_PIN_MODE_GAIN_ADDR = 16'hFF9F;
  localparam logic [15:0] CPU_CLOCK_DIVIDER_ADDR = 16'hFFFB;
  localparam logic [15:0] INTERNAL_OSC_MODE_ADDR = 16'hFFA0;
  localparam logic [15:0] MAIN_CLOCK_MODE_ADDR = 16'hFFA1;
  localparam logic [15:0] MAIN_OSC_CONTROL_ADDR = 16'hFFA2;
  localparam logic [7:0] OSC_PIN_MODE_GAIN_RST = 8'h00;
  localparam logic [7:0] CPU_CLOCK_DIVIDER_RST = 8'h01;
  localparam logic [7:0] INTERNAL_OSC_MODE_RST = 8'h00;
  localparam logic [7:0] MAIN_CLOCK_MODE_RST = 8'h00;
  localparam logic [7:0] MAIN_OSC_CONTROL_RST = 8'h80;
  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int EXTERNAL_CLOCK_SELECT_POS = 7;
  localparam int OSCILLATOR_SELECT_POS = 6;
  localparam int GAIN_RANGE_BIT_POS = 0;
  localparam int HIGH_SPEED_STOP_BIT_POS = 7;
  localparam int HIGH_SPEED_OSC_STABLE_POS = 7;
  localparam int LOW_SPEED_OSC_STOP_POS = 1;
  localparam int INTERNAL_HIGH_OSC_STOP_POS = 0;
  localparam int HIGH_SPEED_SOURCE_SELECT_POS = 2;
  localparam int MAIN_CLOCK_STATUS_POS = 1;
  localparam int MAIN_SOURCE_SELECT_POS = 0;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int GAIN_HOLD_MIN_NS = 4060;
  localparam int GAIN_HOLD_CYCLES = (GAIN_HOLD_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int EXT_HOLD_EDGES = 160;
  localparam int HOLD_CNT_W = 8;
  localparam int DIV_CNT_W = 4;
  localparam logic [7:0] INTERNAL_OSC_SETTLE_CYCLES = 8'h20;

  typedef enum logic [1:0] {
    SCD_RUN = 2'b00,
    SCD_HOLD_INT = 2'b01,
    SCD_HOLD_EXT = 2'b10,
    SCD_HOLD_STAB = 2'b11
  } scd_hold_e;

  typedef struct packed {
    logic crystal_osc_enable;
    logic internal_high_osc_enable;
    logic external_clock_enable;
    logic low_speed_osc_enable;
    logic crystal_pin_a_port_mode;
    logic crystal_pin_b_port_mode;
  } scd_osc_ctrl_s;
endpackage

// [rtl/scd_clock_ctrl.sv]
// Purpose: main clock source select, pin mode, gain and cpu clock divider
// Assumes: oscillator clocks arrive as enable-rate levels sampled on ref_clk_in
// Notes: cpu clock is delivered as a one-cycle enable pulse, glitch-free by design
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// - after reset the cpu runs from the internal high-speed oscillator
// - crystal oscillator stops on stop mode or high-speed stop bit
// - internal high-speed oscillator stops on stop mode or its stop bit
// - external clock input gated off in stop mode or when disabled
// - main clock source chosen by main clock mode register
// - low-speed oscillator runs after every reset release without software
// - low-speed stop honoured only when option byte permits software stop
// - low-speed clock never reaches cpu; only watchdog and timer one
// - pin mode and gain register resets to zero, byte or bit writable
// - gain bit accepts one change per reset release only
// - gain bit set gates cpu clock 4.06 us crystal or 160 external edges
// - stop release with gain set holds cpu clock likewise
// - stop release with crystal and gain set waits for stabilization count instead of the hold
// - divider register resets to divide by two, codes give 1 to 16
// - high-speed stop bit stops crystal or blocks external pin
// - main clock mode register resets to zero selecting internal clock
// - oscillator stable bit reads zero after reset then sets itself
module scd_clock_ctrl
  import scd_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic wr_en_in,
  input wire logic [15:0] wr_addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic [15:0] rd_addr_in,
  input wire logic stop_mode_in,
  input wire logic low_speed_sw_stop_allowed_in,
  input wire logic internal_high_clk_in,
  input wire logic crystal_clk_in,
  input wire logic external_clk_in,
  input wire logic low_speed_clk_in,
  input wire logic stab_count_done_in,
  output logic [7:0] rd_data_out,
  output logic cpu_clk_en_out,
  output logic periph_clk_en_out,
  output logic watchdog_clk_en_out,
  output logic timer_one_low_clk_en_out,
  output logic stab_count_start_out,
  output scd_osc_ctrl_s osc_ctrl_out
);
  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  logic [7:0] osc_pin_mode_gain_reg, osc_pin_mode_gain_next;
  logic [7:0] cpu_clock_divider_reg, cpu_clock_divider_next;
  logic [7:0] internal_osc_mode_reg, internal_osc_mode_next;
  logic [7:0] main_clock_mode_reg, main_clock_mode_next;
  logic [7:0] main_osc_control_reg, main_osc_control_next;
  logic gain_locked_reg, gain_locked_next;
  logic [7:0] settle_cnt_reg, settle_cnt_next;
  logic stop_mode_reg;
  scd_hold_e hold_state_reg, hold_state_next;
  logic [HOLD_CNT_W-1:0] hold_cnt_reg, hold_cnt_next;
  logic [DIV_CNT_W-1:0] div_cnt_reg, div_cnt_next;
  logic [2:0] div_sel_reg, div_sel_next;
  logic src_sel_reg, src_sel_next;
  logic [7:0] rd_data_next;
  logic crystal_prev_reg, external_prev_reg, internal_prev_reg, low_prev_reg;
  logic stab_start_reg, stab_start_next;

  function automatic logic [DIV_CNT_W-1:0] div_last(input logic [2:0] code);
    unique case (code)
      3'h0: div_last = 4'h0;
      3'h1: div_last = 4'h1;
      3'h2: div_last = 4'h3;
      3'h3: div_last = 4'h7;
      default: div_last = 4'hF;
    endcase
  endfunction

  logic ext_mode, xtal_mode, crystal_run, external_run, internal_run, low_run;
  logic high_edge, int_edge, main_edge, low_edge, ext_edge, stop_release;
  logic [7:0] wdata_pin;

  always_comb
  begin
    ext_mode = osc_pin_mode_gain_reg[EXTERNAL_CLOCK_SELECT_POS]
               & osc_pin_mode_gain_reg[OSCILLATOR_SELECT_POS];
    xtal_mode = ~osc_pin_mode_gain_reg[EXTERNAL_CLOCK_SELECT_POS]
                & osc_pin_mode_gain_reg[OSCILLATOR_SELECT_POS];
    crystal_run = xtal_mode & ~main_osc_control_reg[HIGH_SPEED_STOP_BIT_POS] & ~stop_mode_in;
    external_run = ext_mode & ~main_osc_control_reg[HIGH_SPEED_STOP_BIT_POS] & ~stop_mode_in;
    internal_run = ~internal_osc_mode_reg[INTERNAL_HIGH_OSC_STOP_POS] & ~stop_mode_in;
    low_run = ~(internal_osc_mode_reg[LOW_SPEED_OSC_STOP_POS] & low_speed_sw_stop_allowed_in);
    ext_edge = external_clk_in & ~external_prev_reg & external_run;
    high_edge = (crystal_clk_in & ~crystal_prev_reg & crystal_run) | ext_edge;
    int_edge = internal_high_clk_in & ~internal_prev_reg & internal_run;
    low_edge = low_speed_clk_in & ~low_prev_reg & low_run;
    main_edge = src_sel_reg ? high_edge : int_edge;
    stop_release = stop_mode_reg & ~stop_mode_in;
    wdata_pin = wr_data_in;
  end

  // ---------------------------------------------------------------
  // register writes
  // ---------------------------------------------------------------
  always_comb
  begin
    osc_pin_mode_gain_next = osc_pin_mode_gain_reg;
    cpu_clock_divider_next = cpu_clock_divider_reg;
    internal_osc_mode_next = internal_osc_mode_reg;
    main_clock_mode_next = main_clock_mode_reg;
    main_osc_control_next = main_osc_control_reg;
    gain_locked_next = gain_locked_reg;
    settle_cnt_next = settle_cnt_reg;
    if (wr_en_in)
    begin
      unique case (wr_addr_in)
        OSC_PIN_MODE_GAIN_ADDR:
        begin
          osc_pin_mode_gain_next[EXTERNAL_CLOCK_SELECT_POS] = wdata_pin[EXTERNAL_CLOCK_SELECT_POS];
          osc_pin_mode_gain_next[OSCILLATOR_SELECT_POS] = wdata_pin[OSCILLATOR_SELECT_POS];
          if (!gain_locked_reg
              && wdata_pin[GAIN_RANGE_BIT_POS] != osc_pin_mode_gain_reg[GAIN_RANGE_BIT_POS])
          begin
            osc_pin_mode_gain_next[GAIN_RANGE_BIT_POS] = wdata_pin[GAIN_RANGE_BIT_POS];
            gain_locked_next = 1'b1;
          end
        end
        CPU_CLOCK_DIVIDER_ADDR:
          cpu_clock_divider_next = {5'h00, wr_data_in[2:0]};
        INTERNAL_OSC_MODE_ADDR:
        begin
          internal_osc_mode_next[LOW_SPEED_OSC_STOP_POS] = wr_data_in[LOW_SPEED_OSC_STOP_POS];
          internal_osc_mode_next[INTERNAL_HIGH_OSC_STOP_POS] =
            wr_data_in[INTERNAL_HIGH_OSC_STOP_POS];
        end
        MAIN_CLOCK_MODE_ADDR:
        begin
          main_clock_mode_next[HIGH_SPEED_SOURCE_SELECT_POS] =
            wr_data_in[HIGH_SPEED_SOURCE_SELECT_POS];
          main_clock_mode_next[MAIN_SOURCE_SELECT_POS] = wr_data_in[MAIN_SOURCE_SELECT_POS];
        end
        MAIN_OSC_CONTROL_ADDR:
          main_osc_control_next[HIGH_SPEED_STOP_BIT_POS] = wr_data_in[HIGH_SPEED_STOP_BIT_POS];
        default:
        begin
        end
      endcase
    end
    if (settle_cnt_reg != INTERNAL_OSC_SETTLE_CYCLES)
      settle_cnt_next = settle_cnt_reg + 8'h01;
    internal_osc_mode_next[HIGH_SPEED_OSC_STABLE_POS] =
      (settle_cnt_reg == INTERNAL_OSC_SETTLE_CYCLES);
    // status shows the source actually feeding the cpu
    main_clock_mode_next[MAIN_CLOCK_STATUS_POS] = src_sel_reg;
  end

  // ---------------------------------------------------------------
  // cpu clock hold and divider
  // ---------------------------------------------------------------
  always_comb
  begin
    hold_state_next = hold_state_reg;
    hold_cnt_next = hold_cnt_reg;
    stab_start_next = 1'b0;
    unique case (hold_state_reg)
      SCD_RUN:
      begin
        if (osc_pin_mode_gain_next[GAIN_RANGE_BIT_POS]
            & ~osc_pin_mode_gain_reg[GAIN_RANGE_BIT_POS])
        begin
          hold_cnt_next = '0;
          if (src_sel_reg & ext_mode)
            hold_state_next = SCD_HOLD_EXT;
          else if (src_sel_reg)
            hold_state_next = SCD_HOLD_INT;
        end
        else if (stop_release & osc_pin_mode_gain_reg[GAIN_RANGE_BIT_POS])
        begin
          hold_cnt_next = '0;
          if (~src_sel_reg)
            hold_state_next = SCD_HOLD_INT;
          else if (ext_mode)
            hold_state_next = SCD_HOLD_EXT;
          else
          begin
            hold_state_next = SCD_HOLD_STAB;
            stab_start_next = 1'b1;
          end
        end
      end
      SCD_HOLD_INT:
      begin
        hold_cnt_next = hold_cnt_reg + 1'b1;
        if (hold_cnt_reg == HOLD_CNT_W'(GAIN_HOLD_CYCLES - 1))
          hold_state_next = SCD_RUN;
      end
      SCD_HOLD_EXT:
      begin
        if (ext_edge)
          hold_cnt_next = hold_cnt_reg + 1'b1;
        if (ext_edge && hold_cnt_reg == HOLD_CNT_W'(EXT_HOLD_EDGES - 1))
          hold_state_next = SCD_RUN;
      end
      SCD_HOLD_STAB:
        if (stab_count_done_in)
          hold_state_next = SCD_RUN;
    endcase
  end

  always_comb
  begin
    div_cnt_next = div_cnt_reg;
    div_sel_next = div_sel_reg;
    src_sel_next = src_sel_reg;
    cpu_clk_en_out = 1'b0;
    if (main_edge && hold_state_reg == SCD_RUN)
    begin
      if (div_cnt_reg >= div_last(div_sel_reg))
      begin
        cpu_clk_en_out = 1'b1;
        div_cnt_next = '0;
        div_sel_next = cpu_clock_divider_reg[2:0];
        src_sel_next = main_clock_mode_reg[MAIN_SOURCE_SELECT_POS];
      end
      else
        div_cnt_next = div_cnt_reg + 1'b1;
    end
    else if (!main_edge && div_cnt_reg == '0)
      src_sel_next = main_clock_mode_reg[MAIN_SOURCE_SELECT_POS];
    periph_clk_en_out = main_clock_mode_reg[HIGH_SPEED_SOURCE_SELECT_POS] ? high_edge : int_edge;
    watchdog_clk_en_out = low_edge;
    timer_one_low_clk_en_out = low_edge;
    stab_count_start_out = stab_start_reg;
    osc_ctrl_out.crystal_osc_enable = crystal_run;
    osc_ctrl_out.internal_high_osc_enable = internal_run;
    osc_ctrl_out.external_clock_enable = external_run;
    osc_ctrl_out.low_speed_osc_enable = low_run;
    osc_ctrl_out.crystal_pin_a_port_mode = ~xtal_mode;
    osc_ctrl_out.crystal_pin_b_port_mode = ~osc_pin_mode_gain_reg[OSCILLATOR_SELECT_POS];
  end

  always_comb
  begin
    unique case (rd_addr_in)
      OSC_PIN_MODE_GAIN_ADDR: rd_data_next = osc_pin_mode_gain_reg;
      CPU_CLOCK_DIVIDER_ADDR: rd_data_next = cpu_clock_divider_reg;
      INTERNAL_OSC_MODE_ADDR: rd_data_next = internal_osc_mode_reg;
      MAIN_CLOCK_MODE_ADDR: rd_data_next = main_clock_mode_reg;
      MAIN_OSC_CONTROL_ADDR: rd_data_next = main_osc_control_reg;
      default: rd_data_next = 8'h00;
    endcase
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!rst_n_in)
    begin
      osc_pin_mode_gain_reg <= OSC_PIN_MODE_GAIN_RST;
      cpu_clock_divider_reg <= CPU_CLOCK_DIVIDER_RST;
      internal_osc_mode_reg <= INTERNAL_OSC_MODE_RST;
      main_clock_mode_reg <= MAIN_CLOCK_MODE_RST;
      main_osc_control_reg <= MAIN_OSC_CONTROL_RST;
      gain_locked_reg <= 1'b0;
      settle_cnt_reg <= 8'h00;
      stop_mode_reg <= 1'b0;
      hold_state_reg <= SCD_RUN;
      hold_cnt_reg <= '0;
      div_cnt_reg <= '0;
      div_sel_reg <= CPU_CLOCK_DIVIDER_RST[2:0];
      src_sel_reg <= 1'b0;
      rd_data_out <= 8'h00;
      crystal_prev_reg <= 1'b0;
      external_prev_reg <= 1'b0;
      internal_prev_reg <= 1'b0;
      low_prev_reg <= 1'b0;
      stab_start_reg <= 1'b0;
    end
    else
    begin
      osc_pin_mode_gain_reg <= osc_pin_mode_gain_next;
      cpu_clock_divider_reg <= cpu_clock_divider_next;
      internal_osc_mode_reg <= internal_osc_mode_next;
      main_clock_mode_reg <= main_clock_mode_next;
      main_osc_control_reg <= main_osc_control_next;
      gain_locked_reg <= gain_locked_next;
      settle_cnt_reg <= settle_cnt_next;
      stop_mode_reg <= stop_mode_in;
      hold_state_reg <= hold_state_next;
      hold_cnt_reg <= hold_cnt_next;
      div_cnt_reg <= div_cnt_next;
      div_sel_reg <= div_sel_next;
      src_sel_reg <= src_sel_next;
      rd_data_out <= rd_data_next;
      crystal_prev_reg <= crystal_clk_in;
      external_prev_reg <= external_clk_in;
      internal_prev_reg <= internal_high_clk_in;
      low_prev_reg <= low_speed_clk_in;
      stab_start_reg <= stab_start_next;
    end
  end
endmodule
`default_nettype wire

// [testbench/scd_osc_model.sv]
// Purpose: oscillator sources that feed the clock select block
// Assumes: each oscillator runs only while its enable is high
// Notes: a stopped oscillator holds its output low
`timescale 1ns/100ps
`default_nettype none
module scd_osc_model
  import scd_pkg::*;
(
  input wire logic clk_in,
  input wire scd_osc_ctrl_s ctrl_in,
  output logic int_high_out,
  output logic crystal_out,
  output logic external_out,
  output logic low_speed_out
);
  logic [3:0] cnt;
  initial
  begin
    cnt = 4'h0;
    {int_high_out, crystal_out, external_out, low_speed_out} = 4'h0;
  end
  // periods: internal 4, crystal 8, external 4, low speed 16 cycles
  always @(posedge clk_in)
  begin
    #1;
    cnt = cnt + 4'h1;
    int_high_out = ctrl_in.internal_high_osc_enable & cnt[1];
    crystal_out = ctrl_in.crystal_osc_enable & cnt[2];
    external_out = ctrl_in.external_clock_enable & cnt[1];
    low_speed_out = ctrl_in.low_speed_osc_enable & cnt[3];
  end
endmodule
`default_nettype wire

// [testbench/scd_clock_ctrl_props.sv]
// Purpose: port-level assertions for the clock select and divider block
// Assumes: one clock domain, synchronous active-low reset
// Notes: oscillator enables are combinational, checked in the same cycle
`timescale 1ns/100ps
`default_nettype none
module scd_clock_ctrl_props
  import scd_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic rst_n_in,
  input wire logic wr_en_in,
  input wire logic [15:0] wr_addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic [15:0] rd_addr_in,
  input wire logic stop_mode_in,
  input wire logic low_speed_sw_stop_allowed_in,
  input wire logic [7:0] rd_data_out,
  input wire logic cpu_clk_en_out,
  input wire logic stab_count_start_out,
  input wire scd_osc_ctrl_s osc_ctrl_out
);
  // ----
  // properties
  // ----
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence s_div_wr;
    wr_en_in && wr_addr_in == CPU_CLOCK_DIVIDER_ADDR && wr_data_in <= 8'h04;
  endsequence
  sequence s_div_look;
    rd_addr_in == CPU_CLOCK_DIVIDER_ADDR
      && !(wr_en_in && wr_addr_in == CPU_CLOCK_DIVIDER_ADDR);
  endsequence
  property p_div_wr;
    s_div_wr ##1 s_div_look |=> rd_data_out == $past(wr_data_in, 2);
  endproperty
  property p_div_rd;
    rd_addr_in == CPU_CLOCK_DIVIDER_ADDR |=> rd_data_out[7:3] == 5'h00;
  endproperty
  property p_rst_rd;
    $rose(rst_n_in) |-> rd_data_out == 8'h00;
  endproperty
  property p_lso_keep;
    !low_speed_sw_stop_allowed_in |-> osc_ctrl_out.low_speed_osc_enable;
  endproperty
  property p_xtal_stop;
    stop_mode_in |-> !osc_ctrl_out.crystal_osc_enable;
  endproperty
  property p_hio_stop;
    stop_mode_in |-> !osc_ctrl_out.internal_high_osc_enable;
  endproperty
  property p_ext_stop;
    stop_mode_in |-> !osc_ctrl_out.external_clock_enable;
  endproperty
  property p_stab_pulse;
    stab_count_start_out |=> !stab_count_start_out;
  endproperty
  property p_cpu_gap;
    cpu_clk_en_out |=> !cpu_clk_en_out;
  endproperty
  a_div_wr: assert property (p_div_wr) else $error("divider readback wrong");
  a_div_rd: assert property (p_div_rd) else $error("divider upper bits set");
  a_rst_rd: assert property (p_rst_rd) else $error("read data not cleared");
  a_lso_keep: assert property (p_lso_keep) else $error("low osc stopped");
  a_xtal_stop: assert property (p_xtal_stop) else $error("crystal runs in stop");
  a_hio_stop: assert property (p_hio_stop) else $error("internal osc runs");
  a_ext_stop: assert property (p_ext_stop) else $error("external clock open");
  a_stab_pulse: assert property (p_stab_pulse) else $error("stab start too long");
  a_cpu_gap: assert property (p_cpu_gap) else $error("cpu tick too short");
endmodule
bind scd_clock_ctrl scd_clock_ctrl_props i_scd_clock_ctrl_props (
  .ref_clk_in(ref_clk_in), .rst_n_in(rst_n_in), .wr_en_in(wr_en_in),
  .wr_addr_in(wr_addr_in), .wr_data_in(wr_data_in), .rd_addr_in(rd_addr_in),
  .stop_mode_in(stop_mode_in), .low_speed_sw_stop_allowed_in(low_speed_sw_stop_allowed_in),
  .rd_data_out(rd_data_out), .cpu_clk_en_out(cpu_clk_en_out),
  .stab_count_start_out(stab_count_start_out), .osc_ctrl_out(osc_ctrl_out));
`default_nettype wire

// [testbench/tb_top.sv]
// Purpose: self-checking bench for the clock select and divider block
// Assumes: oscillator model drives all four source inputs
// Notes: cpu tick spacing is measured in reference clock cycles
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import scd_pkg::*;
;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic wr_en = 1'b0;
  logic [15:0] wa = 16'h0000;
  logic [15:0] ra = 16'h0000;
  logic [7:0] wd = 8'h00;
  logic stop = 1'b0;
  logic allow = 1'b0;
  logic done = 1'b1;
  logic ih, xt, ex, lo, cpu, sst, pe, wdg, tmr;
  logic [7:0] rd;
  scd_osc_ctrl_s oc;
  int error_cnt = 0;
  int check_count = 0;
  int n;
  always #50 clk = ~clk;
  scd_osc_model i_scd_osc_model (.clk_in(clk), .ctrl_in(oc), .int_high_out(ih),
    .crystal_out(xt), .external_out(ex), .low_speed_out(lo));
  scd_clock_ctrl i_scd_clock_ctrl (.ref_clk_in(clk), .rst_n_in(rst_n), .wr_en_in(wr_en),
    .wr_addr_in(wa), .wr_data_in(wd), .rd_addr_in(ra), .stop_mode_in(stop),
    .low_speed_sw_stop_allowed_in(allow), .internal_high_clk_in(ih), .crystal_clk_in(xt),
    .external_clk_in(ex), .low_speed_clk_in(lo), .stab_count_done_in(done),
    .rd_data_out(rd), .cpu_clk_en_out(cpu), .periph_clk_en_out(pe), .watchdog_clk_en_out(wdg),
    .timer_one_low_clk_en_out(tmr), .stab_count_start_out(sst), .osc_ctrl_out(oc));
  // ----
  // shared tasks
  // ----
  task automatic test_done;
    if (error_cnt == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    {wr_en, wa, ra, wd} = {1'b1, a, a, d};
    @(posedge clk);
    #1;
    wr_en = 1'b0;
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk);
    #1;
    ra = a;
    @(posedge clk);
    #1;
    chk(rd, exp);
  endtask
  // counts cycles up to and including the next cpu tick
  task automatic tick;
    n = 0;
    do
    begin
      @(posedge clk);
      #2;
      n++;
    end
    while (cpu !== 1'b1 && n < 400);
    if (n >= 400)
    begin
      error_cnt++;
      $display("Error %0t: no cpu tick", $time);
      test_done();
    end
  endtask
  task automatic tick3;
    repeat (3) tick();
  endtask
  // counts peripheral ticks and matching watchdog/timer ticks
  task automatic cnt_ev(input int cyc, output int kp, output int kw);
    kp = 0;
    kw = 0;
    repeat (cyc)
    begin
      @(posedge clk);
      #2;
      kp += int'(pe === 1'b1);
      kw += int'(wdg === 1'b1 && tmr === 1'b1);
    end
  endtask
  task automatic wait_stop(input logic d);
    @(posedge clk);
    #1;
    {stop, done} = {1'b1, d};
    repeat (5) @(posedge clk);
    #1;
    stop = 1'b0;
  endtask
  // ----
  // scenarios
  // ----
  task automatic t_reset;
    logic [15:0] adr [6] = '{16'hFF9F, 16'hFFFB, 16'hFFA1, 16'hFFA2, 16'hFFA0, 16'h0000};
    logic [7:0] val [6] = '{8'h00, 8'h01, 8'h00, 8'h80, 8'h00, 8'h00};
    int kp, kw;
    for (int i = 0; i < 6; i++)
      rd_chk(adr[i], val[i]);
    chk({6'h00, oc.internal_high_osc_enable, oc.low_speed_osc_enable}, 8'h03);
    cnt_ev(16, kp, kw);
    chk(8'(kp), 8'h04);
    tick3();
    chk(8'(n), 8'h08);
    repeat (40) @(posedge clk);
    rd_chk(16'hFFA0, 8'h80);
  endtask
  task automatic t_div;
    for (int c = 4; c >= 0; c--)
    begin
      wr(16'hFFFB, 8'(c));
      rd_chk(16'hFFFB, 8'(c));
      tick3();
      chk(8'(n), 8'(4 << c));
    end
  endtask
  task automatic t_pins;
    logic [7:0] mode [4] = '{8'h00, 8'h40, 8'h80, 8'hC0};
    logic [7:0] port [4] = '{8'h03, 8'h00, 8'h03, 8'h02};
    for (int i = 0; i < 4; i++)
    begin
      wr(16'hFF9F, mode[i]);
      rd_chk(16'hFF9F, mode[i]);
      chk({6'h00, oc.crystal_pin_a_port_mode, oc.crystal_pin_b_port_mode}, port[i]);
    end
  endtask
  task automatic t_gain;
    int m;
    wr(16'hFF9F, 8'h40);
    wr(16'hFFA2, 8'h00);
    chk({7'h00, oc.crystal_osc_enable}, 8'h01);
    wr(16'hFFA1, 8'h05);
    tick3();
    chk(8'(n), 8'h08);
    wr(16'hFF9F, 8'h41);
    tick();
    chk({7'h00, n >= 41 && n <= 180}, 8'h01);
    wr(16'hFF9F, 8'h40);
    rd_chk(16'hFF9F, 8'h41);
    wait_stop(1'b0);
    m = 0;
    repeat (20)
    begin
      @(posedge clk);
      #1;
      m = (sst === 1'b1) ? 1 : m;
    end
    chk(8'(m), 8'h01);
    done = 1'b1;
    tick();
    wr(16'hFFA1, 8'h00);
    tick();
    wr(16'hFFA2, 8'h80);
    chk({7'h00, oc.crystal_osc_enable}, 8'h00);
    wait_stop(1'b1);
    tick();
    chk({7'h00, n >= 41 && n <= 180}, 8'h01);
  endtask
  task automatic t_low;
    int kp, kw;
    wr(16'hFFA0, 8'h02);
    chk({7'h00, oc.low_speed_osc_enable}, 8'h01);
    allow = 1'b1;
    wr(16'hFFA0, 8'h02);
    chk({7'h00, oc.low_speed_osc_enable}, 8'h00);
    cnt_ev(32, kp, kw);
    chk(8'(kw), 8'h00);
    wr(16'hFFA0, 8'h00);
    chk({7'h00, oc.low_speed_osc_enable}, 8'h01);
    cnt_ev(48, kp, kw);
    chk({7'h00, kw >= 2}, 8'h01);
  endtask
  task automatic t_rerst;
    @(posedge clk);
    #1;
    rst_n = 1'b0;
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'b1;
    rd_chk(16'hFFA1, 8'h00);
    rd_chk(16'hFF9F, 8'h00);
    tick3();
    chk(8'(n), 8'h08);
    wr(16'hFF9F, 8'h01);
    rd_chk(16'hFF9F, 8'h01);
  endtask
  initial
  begin
    repeat (10) @(posedge clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_div();
    t_pins();
    t_gain();
    t_low();
    t_rerst();
    test_done();
  end
endmodule
`default_nettype wire
